// file: logic/mcd_pkg.sv
// Package of the multiply / complement / OR datapath.
// Assumes a single 40 MHz clock domain; shared by the datapath and its shifter.
package mcd_pkg;

  // Operation select
  typedef enum logic [1:0] {
    MCD_OP_PRODUCT = 2'b00,
    MCD_OP_MOVE_INV = 2'b01,
    MCD_OP_OR = 2'b10,
    MCD_OP_BIT_CLEAR = 2'b11
  } mcd_op_e;

  // Shift kinds of the flexible operand
  typedef enum logic [1:0] {
    MCD_SH_LEFT = 2'b00,
    MCD_SH_LRIGHT = 2'b01,
    MCD_SH_ARIGHT = 2'b10,
    MCD_SH_ROTATE = 2'b11
  } mcd_shift_e;

  // Datapath sequencer states
  typedef enum logic [1:0] {
    MCD_ST_IDLE = 2'b00,
    MCD_ST_MUL = 2'b01,
    MCD_ST_DONE = 2'b10
  } mcd_state_e;

  // Condition codes
  localparam logic [3:0] MCD_COND_AL = 4'he;
  localparam logic [3:0] MCD_COND_NV = 4'hf;

  // Word width and program counter register number
  localparam int MCD_W = 32;
  localparam logic [3:0] MCD_PC_REG = 4'hf;

  // Program counter offsets for multiply operands
  localparam logic [31:0] MCD_PC_OFS_FIRST = 32'h0000000c;
  localparam logic [31:0] MCD_PC_OFS_SECOND = 32'h00000008;
  // Address field of the combined program counter / status word
  localparam logic [31:0] MCD_PC_ADDR_MASK = 32'h03fffffc;

  // Booth steps: each step retires two multiplier bits
  localparam logic [4:0] MCD_MUL_MAX_STEPS = 5'h10;
  localparam logic [4:0] MCD_MUL_SHORT_STEPS = 5'h08;

  // Immediate field layout
  localparam int MCD_IMM_LSB = 0;
  localparam int MCD_IMM_ROT_LSB = 8;

  // Reset values
  localparam logic [31:0] MCD_RESET_WORD = 32'h00000000;
  localparam logic [3:0] MCD_RESET_FLAGS = 4'h0;

endpackage

// file: logic/mcd_shifter.sv
// Barrel shifter for the flexible operand: kind, count and carry-out.
// Assumes combinational use inside the datapath on the same clock.
`timescale 1ns/1ps
`default_nettype none
module mcd_shifter
  import mcd_pkg::*;
(
  input wire logic [31:0] value,
  input wire mcd_shift_e kind,
  input wire logic [7:0] amount,
  input wire logic imm_amount,
  input wire logic carry_in,
  output logic [31:0] result,
  output logic carry_out
);

  // Shift with carry; immediate count 0 encodes the special forms
  always_comb begin
    logic [64:0] wide;
    logic [5:0] n;
    wide = '0;
    n = 6'h00;
    result = value;
    carry_out = carry_in;
    if (imm_amount && amount == 8'h00) begin
      // Immediate zero: left is plain pass, right forms mean 32, rotate means extension
      case (kind)
        MCD_SH_LEFT: begin
          result = value;
        end
        MCD_SH_LRIGHT: begin
          result = 32'h00000000;
          carry_out = value[31];
        end
        MCD_SH_ARIGHT: begin
          result = {32{value[31]}};
          carry_out = value[31];
        end
        default: begin
          // Rotate through carry by one
          result = {carry_in, value[31:1]};
          carry_out = value[0];
        end
      endcase
    end else if (amount == 8'h00) begin
      // Register count of zero keeps value and carry
      result = value;
    end else begin
      case (kind)
        MCD_SH_LEFT: begin
          if (amount > 8'h20) begin
            result = 32'h00000000;
            carry_out = 1'b0;
          end else begin
            n = amount[5:0];
            wide = {33'h0, value} << n;
            result = wide[31:0];
            carry_out = wide[32];
          end
        end
        MCD_SH_LRIGHT: begin
          if (amount > 8'h20) begin
            result = 32'h00000000;
            carry_out = 1'b0;
          end else begin
            n = amount[5:0];
            wide = {value, 33'h0} >> n;
            result = wide[64:33];
            carry_out = wide[32];
          end
        end
        MCD_SH_ARIGHT: begin
          if (amount >= 8'h20) begin
            result = {32{value[31]}};
            carry_out = value[31];
          end else begin
            n = amount[5:0];
            wide = {{32{value[31]}}, value, 1'b0} >> n;
            result = wide[32:1];
            carry_out = wide[0];
          end
        end
        default: begin
          n = {1'b0, amount[4:0]};
          wide = {1'b0, value, value} >> n;
          result = wide[31:0];
          carry_out = wide[31];
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: logic/mcd_datapath.sv
// Execution datapath for product, move-inverted and bitwise-or operations.
// Assumes a decoder presents one operation with a start pulse and waits for done.
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mcd_datapath
  import mcd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire mcd_op_e op,
  input wire logic [3:0] cond,
  input wire logic set_flags,
  input wire logic [3:0] dest_reg,
  input wire logic [3:0] first_operand_reg,
  input wire logic [3:0] second_operand_reg,
  input wire logic [31:0] first_operand,
  input wire logic [31:0] second_operand,
  input wire logic [31:0] base_operand,
  input wire logic [31:0] instr_pc,
  input wire logic [31:0] processor_status_word,
  input wire logic imm_form,
  input wire logic [11:0] imm_field,
  input wire mcd_shift_e shift_kind,
  input wire logic shift_by_reg,
  input wire logic [4:0] shift_imm,
  input wire logic [31:0] shift_count_reg,
  input wire logic [3:0] flags_in,
  output logic busy,
  output logic done,
  output logic write_en,
  output logic [3:0] write_reg,
  output logic [31:0] write_data,
  output logic flags_we,
  output logic [3:0] flags_out
);

  // All registered state of the datapath
  typedef struct packed {
    // Sequencer position
    mcd_state_e state;
    // Running low word of the product
    logic [31:0] acc;
    // Multiplicand, moved up two places per Booth step
    logic [31:0] mcand;
    // Multiplier with a sign bit on top and a guard zero below
    logic [33:0] mplier;
    // Booth steps still to run
    logic [4:0] steps;
    // Destination captured at the start of a product
    logic [3:0] dreg;
    // Flag-setting suffix captured at the start of a product
    logic sflag;
    // Flags at the start, source of the kept C and V
    logic [3:0] flags_base;
    // One-cycle end-of-operation pulse
    logic done;
    // One-cycle register write pulse
    logic wen;
    // Register number and value, held until the next write
    logic [3:0] wreg;
    logic [31:0] wdata;
    // One-cycle flag write pulse and the flags it carries
    logic fwe;
    logic [3:0] fout;
  } mcd_state_s;

  mcd_state_s cur_q;
  mcd_state_s nxt_d;

  // Flag bit order in flags_in/flags_out: {N, Z, C, V}
  // Condition field met by the current flags
  logic cond_pass;
  // Product operands after program counter substitution
  logic [31:0] mul_a;
  logic [31:0] mul_b;
  // Expanded immediate and the shifted register form
  logic [31:0] imm_word;
  logic [31:0] shifter_out;
  logic shifter_carry;
  // Result of the single-cycle operations
  logic [31:0] logic_res;
  // Booth partial product and the sum it leads to
  logic [31:0] booth_pp;
  logic [31:0] acc_next;

  always_comb begin
    logic n;
    logic z;
    logic c;
    logic v;
    {n, z, c, v} = flags_in;
    // Codes 0 to d are the usual tests, e always passes, f never does
    case (cond)
      4'h0: cond_pass = z;
      4'h1: cond_pass = !z;
      4'h2: cond_pass = c;
      4'h3: cond_pass = !c;
      4'h4: cond_pass = n;
      4'h5: cond_pass = !n;
      4'h6: cond_pass = v;
      4'h7: cond_pass = !v;
      4'h8: cond_pass = c && !z;
      4'h9: cond_pass = !c || z;
      4'ha: cond_pass = (n == v);
      4'hb: cond_pass = (n != v);
      4'hc: cond_pass = !z && (n == v);
      4'hd: cond_pass = z || (n != v);
      MCD_COND_AL: cond_pass = 1'b1;
      default: cond_pass = 1'b0;
    endcase
  end

  // The status bits ride above and below the address field of the counter
  // PC as first operand carries status, plus 12
  assign mul_a = (first_operand_reg == MCD_PC_REG) ?
    ((instr_pc + MCD_PC_OFS_FIRST) & MCD_PC_ADDR_MASK) |
    (processor_status_word & ~MCD_PC_ADDR_MASK) : first_operand;
  // PC as second operand masked, plus 8
  assign mul_b = (second_operand_reg == MCD_PC_REG) ?
    ((instr_pc + MCD_PC_OFS_SECOND) & MCD_PC_ADDR_MASK) : second_operand;

  // 8-bit immediate rotated right by twice the rotate field
  // The rotate field counts pairs, so the word turns by even amounts only
  always_comb begin
    logic [63:0] twice;
    logic [4:0] rot;
    rot = {imm_field[MCD_IMM_ROT_LSB +: 4], 1'b0};
    twice = {24'h0, imm_field[MCD_IMM_LSB +: 8], 24'h0, imm_field[MCD_IMM_LSB +: 8]} >> rot;
    imm_word = twice[31:0];
  end

  // register count taken from its low byte
  // Carry in is the current C flag, used by the extension form
  mcd_shifter u_shifter (
    .value(second_operand),
    .kind(shift_kind),
    .amount(shift_by_reg ? shift_count_reg[7:0] : {3'h0, shift_imm}),
    .imm_amount(!shift_by_reg),
    .carry_in(flags_in[1]),
    .result(shifter_out),
    .carry_out(shifter_carry)
  );

  // Logical results of the single-cycle operations
  always_comb begin
    logic [31:0] flex;
    flex = imm_form ? imm_word : shifter_out;
    case (op)
      MCD_OP_MOVE_INV: logic_res = 32'hffffffff ^ flex;
      MCD_OP_OR: logic_res = base_operand | flex;
      // Bit-clear shares the path; the default passes the operand through
      MCD_OP_BIT_CLEAR: logic_res = base_operand & ~flex;
      default: logic_res = flex;
    endcase
  end

  // radix-4 Booth digit from three multiplier bits
  // Digit from two fresh bits and the guard below them; values -2 to +2
  always_comb begin
    case (cur_q.mplier[2:0])
      3'b001, 3'b010: booth_pp = cur_q.mcand;
      3'b011: booth_pp = {cur_q.mcand[30:0], 1'b0};
      3'b100: booth_pp = -{cur_q.mcand[30:0], 1'b0};
      3'b101, 3'b110: booth_pp = -cur_q.mcand;
      default: booth_pp = 32'h00000000;
    endcase
  end
  // only the low 32 bits accumulate
  assign acc_next = cur_q.acc + booth_pp;

  // Next-state logic of the sequencer
  // Pulses default low; held outputs keep their last value
  always_comb begin
    logic n_flag;
    logic z_flag;
    nxt_d = cur_q;
    nxt_d.done = 1'b0;
    nxt_d.wen = 1'b0;
    nxt_d.fwe = 1'b0;
    n_flag = 1'b0;
    z_flag = 1'b0;
    case (cur_q.state)
      MCD_ST_IDLE: begin
        if (start) begin
          if (!cond_pass) begin
            nxt_d.done = 1'b1;
          end else if (op == MCD_OP_PRODUCT) begin
            // Operands are captured here, so the source may move on at once
            // two's complement, sign bit extends the multiplier
            nxt_d.state = MCD_ST_MUL;
            nxt_d.acc = 32'h00000000;
            nxt_d.mcand = mul_a;
            nxt_d.mplier = {mul_b[31], mul_b, 1'b0};
            // early exit when upper half clear
            nxt_d.steps = (mul_b[31:16] == 16'h0000) ? MCD_MUL_SHORT_STEPS :
              MCD_MUL_MAX_STEPS;
            nxt_d.dreg = dest_reg;
            nxt_d.sflag = set_flags;
            nxt_d.flags_base = flags_in;
          end else begin
            nxt_d.done = 1'b1;
            // PC target writes address only, status kept
            nxt_d.wen = 1'b1;
            nxt_d.wreg = dest_reg;
            nxt_d.wdata = (dest_reg == MCD_PC_REG) ?
              (logic_res & MCD_PC_ADDR_MASK) : logic_res;
            if (set_flags) begin
              // N, Z from result, C from shifter (kept for an immediate), V kept
              nxt_d.fwe = 1'b1;
              nxt_d.fout = {logic_res[31], logic_res == 32'h00000000,
                imm_form ? flags_in[1] : shifter_carry, flags_in[0]};
            end
          end
        end
      end
      MCD_ST_MUL: begin
        // two multiplier bits retired each clock
        // The multiplier shifts arithmetically so its sign feeds the last digit
        nxt_d.acc = acc_next;
        nxt_d.mcand = {cur_q.mcand[29:0], 2'b00};
        nxt_d.mplier = {{2{cur_q.mplier[33]}}, cur_q.mplier[33:2]};
        nxt_d.steps = cur_q.steps - 5'h01;
        if (cur_q.steps == 5'h01) begin
          nxt_d.state = MCD_ST_DONE;
        end
      end
      MCD_ST_DONE: begin
        // destination hazards still write and finish
        // destination never the PC, so no masking
        // destination distinct from first operand assumed
        // a short run still owes the digit that holds multiplier bit 15
        // after a full run that digit is zero, so both lengths take acc_next
        nxt_d.state = MCD_ST_IDLE;
        nxt_d.done = 1'b1;
        nxt_d.wen = 1'b1;
        nxt_d.wreg = cur_q.dreg;
        nxt_d.wdata = acc_next;
        n_flag = acc_next[31];
        z_flag = (acc_next == 32'h00000000);
        if (cur_q.sflag) begin
          // N, Z set, C left as is (undefined), V kept
          nxt_d.fwe = 1'b1;
          nxt_d.fout = {n_flag, z_flag, cur_q.flags_base[1:0]};
        end
      end
      default: begin
        nxt_d.state = MCD_ST_IDLE;
      end
    endcase
  end

  // State register
  // Only constants under reset; the whole state clears at once
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cur_q <= '{state: MCD_ST_IDLE, acc: MCD_RESET_WORD, mcand: MCD_RESET_WORD,
        mplier: 34'h0, steps: 5'h00, dreg: 4'h0, sflag: 1'b0,
        flags_base: MCD_RESET_FLAGS, done: 1'b0, wen: 1'b0, wreg: 4'h0,
        wdata: MCD_RESET_WORD, fwe: 1'b0, fout: MCD_RESET_FLAGS};
    end else begin
      cur_q <= nxt_d;
    end
  end

  // Outputs
  // Busy covers the Booth steps and the closing cycle of a product
  // Every other output comes straight from a flip-flop
  assign busy = (cur_q.state != MCD_ST_IDLE);
  assign done = cur_q.done;
  assign write_en = cur_q.wen;
  assign write_reg = cur_q.wreg;
  assign write_data = cur_q.wdata;
  assign flags_we = cur_q.fwe;
  assign flags_out = cur_q.fout;

endmodule
`default_nettype wire

// file: verif/mcd_datapath_monitor.sv
// Checker of the datapath: timing of done, write pulses and flag relations.
// Assumes it is bound to mcd_datapath and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mcd_datapath_monitor
  import mcd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire mcd_op_e op,
  input wire logic [3:0] cond,
  input wire logic set_flags,
  input wire logic [3:0] second_operand_reg,
  input wire logic [31:0] instr_pc,
  input wire logic [31:0] second_operand,
  input wire logic [3:0] flags_in,
  input wire logic busy,
  input wire logic done,
  input wire logic write_en,
  input wire logic [3:0] write_reg,
  input wire logic [31:0] write_data,
  input wire logic flags_we,
  input wire logic [3:0] flags_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Accepted request that always executes, and its product form
  logic go;
  logic mul;
  assign go = start && !busy && cond == MCD_COND_AL;
  assign mul = go && op == MCD_OP_PRODUCT;
  // Multiplier as the product sees it, the program counter form included
  logic [31:0] mplier_word;
  logic mplier_short;
  assign mplier_word = (second_operand_reg == MCD_PC_REG) ?
    ((instr_pc + MCD_PC_OFS_SECOND) & MCD_PC_ADDR_MASK) : second_operand;
  assign mplier_short = (mplier_word[31:16] == 16'h0000);

  a_logic_one_cycle: assert property (start && !busy && op != MCD_OP_PRODUCT |=> done)
    else $error("logic operation did not finish in one cycle");
  a_short_product: assert property (mul && mplier_short
    |=> busy [*8] ##1 busy ##1 (done && !busy)) else $error("short product timing wrong");
  a_long_product: assert property (mul && !mplier_short
    |=> busy [*8] ##10 (done && !busy)) else $error("long product timing wrong");
  a_never_quiet: assert property (start && !busy && cond == MCD_COND_NV
    |=> done && !write_en && !flags_we) else $error("false condition wrote");
  a_write_with_done: assert property (write_en || flags_we |-> done)
    else $error("write pulse without done");
  a_logic_v_kept: assert property (go && op != MCD_OP_PRODUCT && set_flags
    |=> flags_we && flags_out[0] == $past(flags_in[0])) else $error("logic op V changed");
  a_product_v_kept: assert property (mul && set_flags && mplier_short
    |-> ##10 flags_we && flags_out[0] == $past(flags_in[0], 10)) else $error("product V changed");
  a_nz_flags: assert property (flags_we && write_reg != MCD_PC_REG
    |-> flags_out[2] == (write_data == 32'h0) && flags_out[3] == write_data[31])
    else $error("N or Z disagrees with result");
  a_done_cause: assert property (done |-> $past(start) || $past(busy))
    else $error("done without request");

  // Main scenarios
  c_short: cover property (mul && mplier_short);
  c_long: cover property (mul && !mplier_short);
  c_flags: cover property (go && op != MCD_OP_PRODUCT && set_flags);
endmodule
bind mcd_datapath mcd_datapath_monitor u_mon (
  .clk(clk),
  .rstn(rstn),
  .start(start),
  .op(op),
  .cond(cond),
  .set_flags(set_flags),
  .second_operand_reg(second_operand_reg),
  .instr_pc(instr_pc),
  .second_operand(second_operand),
  .flags_in(flags_in),
  .busy(busy),
  .done(done),
  .write_en(write_en),
  .write_reg(write_reg),
  .write_data(write_data),
  .flags_we(flags_we),
  .flags_out(flags_out)
);
`default_nettype wire

// file: verif/mcd_datapath_tb.sv
// Testbench: random product and logical operations checked against a bench model.
// Assumes the datapath and its bound checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module mcd_datapath_tb
  import mcd_pkg::*;
;
  // Stimulus with the port names of the design
  logic clk, rstn, start, set_flags, imm_form, shift_by_reg;
  mcd_op_e op;
  mcd_shift_e shift_kind;
  logic [3:0] cond, dest_reg, first_operand_reg, second_operand_reg, flags_in;
  logic [31:0] first_operand, second_operand, base_operand, instr_pc;
  logic [31:0] processor_status_word, shift_count_reg;
  logic [11:0] imm_field;
  logic [4:0] shift_imm;
  // Design answers
  logic busy, done, write_en, flags_we;
  logic [3:0] write_reg, flags_out;
  logic [31:0] write_data;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  mcd_datapath dut (
    .clk(clk),
    .rstn(rstn),
    .start(start),
    .op(op),
    .cond(cond),
    .set_flags(set_flags),
    .dest_reg(dest_reg),
    .first_operand_reg(first_operand_reg),
    .second_operand_reg(second_operand_reg),
    .first_operand(first_operand),
    .second_operand(second_operand),
    .base_operand(base_operand),
    .instr_pc(instr_pc),
    .processor_status_word(processor_status_word),
    .imm_form(imm_form),
    .imm_field(imm_field),
    .shift_kind(shift_kind),
    .shift_by_reg(shift_by_reg),
    .shift_imm(shift_imm),
    .shift_count_reg(shift_count_reg),
    .flags_in(flags_in),
    .busy(busy),
    .done(done),
    .write_en(write_en),
    .write_reg(write_reg),
    .write_data(write_data),
    .flags_we(flags_we),
    .flags_out(flags_out)
  );

  // Free running clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Right rotation; a zero count leaves the word alone
  function automatic logic [31:0] rotr(logic [31:0] v, logic [4:0] r);
    return (v >> r) | (v << (6'd32 - r));
  endfunction

  // Flexible operand as {carry, value}
  function automatic logic [32:0] flex();
    logic [7:0] a;
    logic [32:0] t;
    // immediate, shift kinds, low count byte
    if (imm_form)
      return {flags_in[1], rotr({24'h0, imm_field[7:0]}, {imm_field[11:8], 1'b0})};
    a = shift_by_reg ? shift_count_reg[7:0] : {3'h0, shift_imm};
    if (a == 8'h0 && (shift_by_reg || shift_kind == MCD_SH_LEFT))
      return {flags_in[1], second_operand};
    if (a == 8'h0 && shift_kind == MCD_SH_ROTATE)
      return {second_operand[0], flags_in[1], second_operand[31:1]};
    if (a == 8'h0)
      a = 8'h20;
    case (shift_kind)
      MCD_SH_LEFT: return {1'b0, second_operand} << a;
      MCD_SH_ROTATE: begin
        t[31:0] = rotr(second_operand, a[4:0]);
        return {t[31], t[31:0]};
      end
      MCD_SH_LRIGHT: t = {second_operand, 1'b0} >> a;
      default: t = $signed({second_operand, 1'b0}) >>> (a > 8'h21 ? 8'h21 : a);
    endcase
    return {t[0], t[32:1]};
  endfunction

  // Condition test against {N,Z,C,V}
  function automatic bit cond_ok(logic [3:0] c, logic [3:0] f);
    bit r;
    case (c[3:1])
      3'h0: r = f[2];
      3'h1: r = f[1];
      3'h2: r = f[3];
      3'h3: r = f[0];
      3'h4: r = f[1] && !f[2];
      3'h5: r = f[3] == f[0];
      3'h6: r = !f[2] && f[3] == f[0];
      default: return c == MCD_COND_AL;
    endcase
    return r ^ c[0];
  endfunction

  // One operation: random fields, wait for done, compare with the model
  task automatic run(mcd_op_e o);
    logic [31:0] w, v, x, a, b, r;
    logic [32:0] f;
    logic [3:0] s, e;
    int n, lat;
    bit ok, ill;
    w = $urandom;
    v = $urandom;
    x = $urandom;
    s = (o != MCD_OP_PRODUCT && v[11:8] == 4'hf) ? 4'h0 : v[11:8];
    // no accumulate operand is ever presented
    @(posedge clk);
    op <= o;
    {set_flags, imm_form, shift_by_reg, flags_in} <= w[6:0];
    {first_operand_reg, shift_imm, imm_field} <= {w[29:26], w[23:7]};
    shift_kind <= mcd_shift_e'(w[25:24]);
    cond <= w[31] ? v[3:0] : MCD_COND_AL;
    dest_reg <= (w[0] && v[7:4] == 4'hf) ? 4'he : v[7:4];
    second_operand_reg <= s;
    instr_pc <= {16'h0, v[27:12]};
    first_operand <= $urandom;
    base_operand <= $urandom;
    processor_status_word <= $urandom;
    second_operand <= (w[30] || s == 4'hf) ? {16'h0, x[15:0]} : x;
    shift_count_reg <= v[28] ? {26'h0, x[5:0]} : x;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    a = (first_operand_reg == MCD_PC_REG) ? ((instr_pc + MCD_PC_OFS_FIRST) & MCD_PC_ADDR_MASK)
      | (processor_status_word & ~MCD_PC_ADDR_MASK) : first_operand;
    b = (s == MCD_PC_REG) ? (instr_pc + MCD_PC_OFS_SECOND) & MCD_PC_ADDR_MASK : second_operand;
    f = flex();
    case (op)
      MCD_OP_PRODUCT: r = a * b;
      MCD_OP_MOVE_INV: r = ~f[31:0];
      MCD_OP_OR: r = base_operand | f[31:0];
      default: r = base_operand & ~f[31:0];
    endcase
    e = {r[31], r == 32'h0, op == MCD_OP_PRODUCT ? flags_in[1] : f[32], flags_in[0]};
    ok = cond_ok(cond, flags_in);
    lat = (!ok || op != MCD_OP_PRODUCT) ? 1 : (b[31:16] == 16'h0 ? 10 : 18);
    ill = op == MCD_OP_PRODUCT && (dest_reg == first_operand_reg || dest_reg == MCD_PC_REG);
    n = 1;
    #1;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("latency", lat, n);
    chk("write_en", {31'h0, ok}, {31'h0, write_en});
    chk("flags_we", {31'h0, ok && set_flags}, {31'h0, flags_we});
    if (ok)
      chk("write_reg", {28'h0, dest_reg}, {28'h0, write_reg});
    if (ok && !ill)
      chk("write_data", dest_reg == MCD_PC_REG ? r & MCD_PC_ADDR_MASK : r, write_data);
    if (ok && !ill && set_flags)
      chk("flags_out", {28'h0, e}, {28'h0, flags_out});
  endtask

  // Main sequence, with a second reset in mid-run
  initial begin
    void'($urandom(45));
    {rstn, start, set_flags, imm_form, shift_by_reg} = '0;
    op = MCD_OP_PRODUCT;
    shift_kind = MCD_SH_LEFT;
    {cond, dest_reg, first_operand_reg, second_operand_reg, flags_in} = '0;
    {imm_field, shift_imm, first_operand, second_operand, base_operand} = '0;
    {instr_pc, processor_status_word, shift_count_reg} = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 360; i++)
      run(mcd_op_e'(i % 4));
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset data", 32'h0, write_data);
    rstn <= 1'b1;
    for (int i = 0; i < 40; i++)
      run(mcd_op_e'(i % 4));
    report_and_stop();
  end
endmodule
`default_nettype wire
